// ---- logic/tbl_link.v ----
// Contract
// - I control byte: b8 clear, b7 send number, b6 more-data, rest reserved.
// - R control byte: b8 set, b7 b6 clear, b5 expected number, low code.
// - R error code 0 clean, 1 check or parity, 2 other; no other codes.
// - S control byte: b8 b7 set; b6 clear request, set response.
// - S type 0 resynch, 1 size, 2 abort, 3 waiting extension; rest reserved.
// - Length counts information bytes 0 to 254; FFh never used.
// - I carries data, R none; size and extension one byte; others none.
// - Every block ends with a one-byte longitudinal check.
// - Unchained I received correctly is answered by our own I-block; the code sends nothing while app_tx_req is low.
// - Chained I received correctly is answered by R with the other number.
// - Card may request waiting extension; terminal answers with extension response.
// - Size request answered with size response holding the same byte.
// - Parity, check, control, length faults, lost sync, missing S response are invalid.
// - Recovery escalates: retransmit, resynch response, then card goes silent; the code retransmits twice, then goes silent.
// - Invalid first received block is answered with R numbered zero.
// - After I, failures bring R for expected I; after R, resend R.
// - Unanswered S request resent; after S response, failures bring R.
// - Card size request resent once at most, then card keeps receiving.
// - Address byte is zero: both addresses zero, b8 and b4 zero.
// - Block order: address, control, length, information, check byte.
//
// Purpose: Card-side block link layer: parses terminal blocks and builds answers.
// Assumes: Bytes move one per strobe; timeout marks the block waiting time expiry.
// Notes: The application supplies outgoing data and requests extensions or size.
`timescale 1ns/1ps
`include "tbl_map.vh"
module tbl_link (
  input wire clk,
  input wire nrst,
  input wire rx_vld,
  input wire [7:0] rx_byte,
  input wire rx_err,
  input wire bwt_timeout,
  input wire tx_rdy,
  output reg tx_vld_r,
  output reg [7:0] tx_byte_r,
  output reg app_rx_vld_r,
  output reg [7:0] app_rx_byte_r,
  output reg app_rx_end_r,
  input wire app_tx_req,
  input wire [7:0] app_tx_len,
  input wire app_tx_more,
  input wire [7:0] app_tx_data,
  output reg app_tx_take_r,
  input wire wtx_req,
  input wire [7:0] wtx_mult,
  input wire ifs_req,
  input wire [7:0] ifs_val,
  output reg [7:0] ifsd_r,
  output reg wtx_ok_r,
  output reg mute_r,
  output reg link_idle_r
);
  // --------------------------------------------------------------------------
  // Received block decode
  // --------------------------------------------------------------------------
  wire [7:0] nad;
  wire [7:0] pcb;
  wire [7:0] len;
  wire [7:0] inf0;
  wire inf_vld;
  wire [7:0] inf_byte;
  wire blk_done;
  wire edc_bad;
  wire par_bad;
  reg [7:0] ifsc_r;

  tbl_rx_parse u_rx (
    .clk(clk),
    .nrst(nrst),
    .abort(mute_r),
    .rx_vld(rx_vld),
    .rx_byte(rx_byte),
    .rx_err(rx_err),
    .nad_r(nad),
    .pcb_r(pcb),
    .len_r(len),
    .inf0_r(inf0),
    .inf_vld_r(inf_vld),
    .inf_r(inf_byte),
    .blk_done_r(blk_done),
    .edc_bad_r(edc_bad),
    .par_bad_r(par_bad)
  );

  wire is_i = ~pcb[`TBL_PCB_B8];
  wire is_r = pcb[`TBL_PCB_B8] & ~pcb[`TBL_PCB_B7];
  wire is_s = pcb[`TBL_PCB_B8] & pcb[`TBL_PCB_B7];
  wire s_rsp = pcb[`TBL_PCB_B6];
  wire [4:0] s_type = pcb[4:0];
  wire nad_ok = (nad == `TBL_NAD_DEFAULT);
  wire r_ok = ~pcb[`TBL_PCB_B6] & (pcb[3:0] <= `TBL_R_ERR_OTHER) & (len == 8'h00);
  wire s_one = (s_type == `TBL_S_IFS) || (s_type == `TBL_S_WTX);
  wire s_none = (s_type == `TBL_S_RESYNCH) || (s_type == `TBL_S_ABORT);
  wire s_ok = (s_one & (len == 8'h01)) | (s_none & (len == 8'h00));
  wire len_ok = (len != `TBL_LEN_RFU) && (len <= ifsc_r);
  wire pcb_ok = is_i | (is_r & r_ok) | (is_s & s_ok);
  wire blk_bad = edc_bad | par_bad | ~nad_ok | ~pcb_ok | ~len_ok;

  // --------------------------------------------------------------------------
  // Protocol state
  // --------------------------------------------------------------------------
  localparam ST_RX = 3'h0;
  localparam ST_TX = 3'h1;
  localparam ST_INF = 3'h2;
  localparam ST_EDC = 3'h3;
  localparam ST_MUTE = 3'h4;
  localparam K_I = 2'h0;
  localparam K_R = 2'h1;
  localparam K_S = 2'h2;

  reg [2:0] st_r;
  reg ns_r;
  reg nr_r;
  reg first_r;
  reg [1:0] retry_r;
  reg [1:0] last_k_r;
  reg [7:0] last_pcb_r;
  reg [7:0] last_len_r;
  reg [7:0] last_inf_r;
  reg s_pend_r;
  reg ifs_out_r;
  reg [7:0] tx_pcb_r;
  reg [7:0] tx_len_r;
  reg [7:0] tx_inf_r;
  reg [1:0] tx_idx_r;
  reg [7:0] tx_cnt_r;
  reg [7:0] tx_lrc_r;
  reg tx_app_r;

  always @(posedge clk) begin
    if (!nrst) begin
      st_r <= ST_RX;
      ifsc_r <= `TBL_IFS_DEFAULT;
      ifsd_r <= `TBL_IFS_DEFAULT;
      ns_r <= 1'b0;
      nr_r <= 1'b0;
      first_r <= 1'b1;
      retry_r <= 2'h0;
      last_k_r <= K_R;
      last_pcb_r <= `TBL_PCB_R;
      last_len_r <= 8'h00;
      last_inf_r <= 8'h00;
      s_pend_r <= 1'b0;
      ifs_out_r <= 1'b0;
      tx_pcb_r <= 8'h00;
      tx_len_r <= 8'h00;
      tx_inf_r <= 8'h00;
      tx_idx_r <= 2'h0;
      tx_cnt_r <= 8'h00;
      tx_lrc_r <= 8'h00;
      tx_app_r <= 1'b0;
      tx_vld_r <= 1'b0;
      tx_byte_r <= 8'h00;
      app_rx_vld_r <= 1'b0;
      app_rx_byte_r <= 8'h00;
      app_rx_end_r <= 1'b0;
      app_tx_take_r <= 1'b0;
      wtx_ok_r <= 1'b0;
      mute_r <= 1'b0;
      link_idle_r <= 1'b1;
    end else begin
      app_rx_vld_r <= inf_vld & ~pcb[`TBL_PCB_B8];
      app_rx_byte_r <= inf_byte;
      app_rx_end_r <= 1'b0;
      app_tx_take_r <= 1'b0;
      wtx_ok_r <= 1'b0;
      link_idle_r <= (st_r == ST_RX);
      case (st_r)
        ST_RX: begin
          if (wtx_req && !s_pend_r) begin
            tx_pcb_r <= `TBL_PCB_S | {3'h0, `TBL_S_WTX};
            tx_len_r <= 8'h01;
            tx_inf_r <= wtx_mult;
            s_pend_r <= 1'b1;
            st_r <= ST_TX;
          end else if (ifs_req && !s_pend_r) begin
            tx_pcb_r <= `TBL_PCB_S | {3'h0, `TBL_S_IFS};
            tx_len_r <= 8'h01;
            tx_inf_r <= ifs_val;
            s_pend_r <= 1'b1;
            ifs_out_r <= 1'b1;
            st_r <= ST_TX;
          end else if (blk_done || bwt_timeout) begin
            st_r <= ST_TX;
            tx_len_r <= 8'h00;
            if (blk_done && !blk_bad && !(s_pend_r && !(is_s && s_rsp))) begin
              retry_r <= 2'h0;
              first_r <= 1'b0;
              if (is_s && s_rsp) begin
                s_pend_r <= 1'b0;
                ifs_out_r <= 1'b0;
                if (s_type == `TBL_S_WTX) wtx_ok_r <= 1'b1;
                if (s_type == `TBL_S_IFS) ifsc_r <= inf0;
                tx_pcb_r <= last_pcb_r;
                tx_len_r <= last_len_r;
                tx_inf_r <= last_inf_r;
                st_r <= ST_RX;
              end else if (is_s) begin
                tx_pcb_r <= pcb | 8'h20;
                tx_len_r <= len;
                tx_inf_r <= inf0;
                if (s_type == `TBL_S_IFS) ifsd_r <= inf0;
                if (s_type == `TBL_S_RESYNCH) begin
                  ns_r <= 1'b0;
                  nr_r <= 1'b0;
                end
              end else if (is_i) begin
                nr_r <= ~pcb[`TBL_PCB_B7];
                app_rx_end_r <= ~pcb[`TBL_PCB_B6];
                if (pcb[`TBL_PCB_B6]) begin
                  tx_pcb_r <= `TBL_PCB_R | {3'h0, ~pcb[`TBL_PCB_B7], `TBL_R_ERR_NONE};
                end else begin
                  st_r <= app_tx_req ? ST_TX : ST_RX;
                  if (app_tx_req) ns_r <= ~ns_r;
                  tx_app_r <= 1'b1;
                  tx_pcb_r <= {1'b0, ns_r, app_tx_more, 5'h00};
                  tx_len_r <= app_tx_len;
                end
              end else begin
                // The number advances as each I-block goes out, so a request
                // naming the current number asks for the next block.
                if (pcb[`TBL_PCB_B5] == ns_r && last_k_r == K_I) begin
                  if (app_tx_req) ns_r <= ~ns_r;
                  tx_app_r <= 1'b1;
                  tx_pcb_r <= {1'b0, ns_r, app_tx_more, 5'h00};
                  tx_len_r <= app_tx_len;
                  st_r <= app_tx_req ? ST_TX : ST_RX;
                end else begin
                  tx_pcb_r <= last_pcb_r;
                  tx_len_r <= last_len_r;
                  tx_inf_r <= last_inf_r;
                end
              end
            end else if (ifs_out_r && retry_r == 2'h1) begin
              st_r <= ST_RX;
              ifs_out_r <= 1'b0;
              s_pend_r <= 1'b0;
              retry_r <= 2'h0;
            end else if (retry_r == `TBL_RETRY_MAX) begin
              st_r <= ST_MUTE;
              mute_r <= 1'b1;
            end else begin
              retry_r <= retry_r + 2'h1;
              if (first_r) begin
                tx_pcb_r <= `TBL_PCB_R | {4'h0, (edc_bad | par_bad) ?
                  `TBL_R_ERR_EDC : `TBL_R_ERR_OTHER};
              end else if (s_pend_r || last_k_r == K_R) begin
                tx_pcb_r <= last_pcb_r;
                tx_len_r <= last_len_r;
                tx_inf_r <= last_inf_r;
              end else begin
                tx_pcb_r <= `TBL_PCB_R | {3'h0, nr_r, (edc_bad | par_bad) ?
                  `TBL_R_ERR_EDC : `TBL_R_ERR_OTHER};
              end
            end
          end
        end
        ST_TX: begin
          if (!tx_vld_r || tx_rdy) begin
            tx_vld_r <= 1'b1;
            case (tx_idx_r)
              2'h0: begin
                tx_byte_r <= `TBL_NAD_DEFAULT;
                tx_lrc_r <= `TBL_NAD_DEFAULT;
                tx_idx_r <= 2'h1;
              end
              2'h1: begin
                tx_byte_r <= tx_pcb_r;
                tx_lrc_r <= tx_lrc_r ^ tx_pcb_r;
                tx_idx_r <= 2'h2;
              end
              default: begin
                tx_byte_r <= tx_len_r;
                tx_lrc_r <= tx_lrc_r ^ tx_len_r;
                tx_cnt_r <= tx_len_r;
                tx_idx_r <= 2'h0;
                st_r <= (tx_len_r == 8'h00) ? ST_EDC : ST_INF;
              end
            endcase
          end
        end
        ST_INF: begin
          // The application advances its data only after the take pulse, so
          // the byte after a take waits one cycle with valid low.
          if (!tx_vld_r || tx_rdy) begin
            if (tx_app_r && app_tx_take_r) begin
              tx_vld_r <= 1'b0;
            end else begin
              tx_vld_r <= 1'b1;
              tx_byte_r <= tx_app_r ? app_tx_data : tx_inf_r;
              tx_lrc_r <= tx_lrc_r ^ (tx_app_r ? app_tx_data : tx_inf_r);
              app_tx_take_r <= tx_app_r;
              tx_cnt_r <= tx_cnt_r - 8'h01;
              if (tx_cnt_r == 8'h01) st_r <= ST_EDC;
            end
          end
        end
        ST_EDC: begin
          if (tx_rdy) begin
            if (tx_vld_r && tx_byte_r == tx_lrc_r && tx_idx_r == 2'h3) begin
              tx_vld_r <= 1'b0;
              tx_idx_r <= 2'h0;
              st_r <= ST_RX;
              last_pcb_r <= tx_pcb_r;
              last_len_r <= tx_app_r ? 8'h00 : tx_len_r;
              last_inf_r <= tx_inf_r;
              last_k_r <= tx_pcb_r[`TBL_PCB_B8] ? (tx_pcb_r[`TBL_PCB_B7] ? K_S : K_R) : K_I;
              tx_app_r <= 1'b0;
            end else begin
              tx_byte_r <= tx_lrc_r;
              tx_idx_r <= 2'h3;
            end
          end
        end
        ST_MUTE: begin
          tx_vld_r <= 1'b0;
        end
        default: begin
          st_r <= ST_RX;
        end
      endcase
    end
  end
endmodule // tbl_link

// ---- logic/tbl_map.vh ----
// Purpose: Constants of the card-side block link layer.
// Assumes: Included by the link and receive parser design files; the check module does not include it.
// Notes: Bit positions count from zero, so b8 of the control byte is bit 7.
`ifndef TBL_MAP_VH
`define TBL_MAP_VH

// ----------------------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------------------
`define TBL_PCB_B8 7
`define TBL_PCB_B7 6
`define TBL_PCB_B6 5
`define TBL_PCB_B5 4
`define TBL_R_ERR_NONE 4'h0
`define TBL_R_ERR_EDC 4'h1
`define TBL_R_ERR_OTHER 4'h2
`define TBL_S_RESYNCH 5'h00
`define TBL_S_IFS 5'h01
`define TBL_S_ABORT 5'h02
`define TBL_S_WTX 5'h03
`define TBL_PCB_I 8'h00
`define TBL_PCB_R 8'h80
`define TBL_PCB_S 8'hC0

// ----------------------------------------------------------------------------
// Block layout
// ----------------------------------------------------------------------------
`define TBL_NAD_DEFAULT 8'h00
`define TBL_LEN_MAX 8'hFE
`define TBL_LEN_RFU 8'hFF
`define TBL_IFS_DEFAULT 8'h20
`define TBL_RETRY_MAX 2'h2

`endif

// ---- logic/tbl_lrc.v ----
// Purpose: Running longitudinal check over the bytes of one block.
// Assumes: Bytes arrive one per strobe; clear precedes each block.
// Notes: The check is a plain XOR of every byte seen since the clear.
`timescale 1ns/1ps
module tbl_lrc #(
  parameter W = 8
) (
  input wire clk,
  input wire nrst,
  input wire clr,
  input wire en,
  input wire [W-1:0] din,
  output reg [W-1:0] lrc_r
);
  always @(posedge clk) begin
    if (!nrst || clr) begin
      lrc_r <= {W{1'b0}};
    end else if (en) begin
      lrc_r <= lrc_r ^ din;
    end
  end
endmodule // tbl_lrc

// ---- logic/tbl_rx_parse.v ----
// Purpose: Splits received bytes into prologue, information field and check byte.
// Assumes: rx_err marks a parity or framing fault on the byte it comes with.
// Notes: blk_done pulses with a verdict once the check byte has arrived.
`timescale 1ns/1ps
`include "tbl_map.vh"
module tbl_rx_parse (
  input wire clk,
  input wire nrst,
  input wire abort,
  input wire rx_vld,
  input wire [7:0] rx_byte,
  input wire rx_err,
  output reg [7:0] nad_r,
  output reg [7:0] pcb_r,
  output reg [7:0] len_r,
  output reg [7:0] inf0_r,
  output reg inf_vld_r,
  output reg [7:0] inf_r,
  output reg blk_done_r,
  output reg edc_bad_r,
  output reg par_bad_r
);
  localparam ST_NAD = 2'h0;
  localparam ST_PCB = 2'h1;
  localparam ST_LEN = 2'h2;
  localparam ST_INF = 2'h3;

  reg [1:0] st_r;
  reg [7:0] cnt_r;
  reg edc_phase_r;
  wire [7:0] lrc;
  wire lrc_clr;

  assign lrc_clr = blk_done_r | abort;

  tbl_lrc #(.W(8)) u_lrc (
    .clk(clk),
    .nrst(nrst),
    .clr(lrc_clr),
    .en(rx_vld & ~edc_phase_r),
    .din(rx_byte),
    .lrc_r(lrc)
  );

  always @(posedge clk) begin
    if (!nrst || abort) begin
      st_r <= ST_NAD;
      cnt_r <= 8'h00;
      edc_phase_r <= 1'b0;
      nad_r <= 8'h00;
      pcb_r <= 8'h00;
      len_r <= 8'h00;
      inf0_r <= 8'h00;
      inf_vld_r <= 1'b0;
      inf_r <= 8'h00;
      blk_done_r <= 1'b0;
      edc_bad_r <= 1'b0;
      par_bad_r <= 1'b0;
    end else begin
      inf_vld_r <= 1'b0;
      blk_done_r <= 1'b0;
      if (blk_done_r) begin
        par_bad_r <= 1'b0;
        edc_bad_r <= 1'b0;
      end
      if (rx_vld) begin
        if (rx_err) begin
          par_bad_r <= 1'b1;
        end
        // Fields arrive in fixed order: address, control, length, data, check.
        case (st_r)
          ST_NAD: begin
            nad_r <= rx_byte;
            st_r <= ST_PCB;
          end
          ST_PCB: begin
            pcb_r <= rx_byte;
            st_r <= ST_LEN;
          end
          ST_LEN: begin
            len_r <= rx_byte;
            cnt_r <= rx_byte;
            st_r <= ST_INF;
            edc_phase_r <= (rx_byte == 8'h00);
          end
          ST_INF: begin
            if (edc_phase_r) begin
              edc_bad_r <= (lrc != rx_byte);
              blk_done_r <= 1'b1;
              edc_phase_r <= 1'b0;
              st_r <= ST_NAD;
            end else begin
              if (cnt_r == len_r) begin
                inf0_r <= rx_byte;
              end
              inf_vld_r <= 1'b1;
              inf_r <= rx_byte;
              cnt_r <= cnt_r - 8'h01;
              edc_phase_r <= (cnt_r == 8'h01);
            end
          end
          default: begin
            st_r <= ST_NAD;
          end
        endcase
      end
    end
  end
endmodule // tbl_rx_parse

// ---- sim/tbl_link_asserts.sv ----
// Purpose: Concurrent checks on the card-side block link outputs.
// Assumes: One clock domain; nrst is synchronous and active low.
// Notes: A helper counter follows the outgoing block byte by byte.
`timescale 1ns/1ps
module tbl_link_asserts (
  input wire clk,
  input wire nrst,
  input wire tx_rdy,
  input wire tx_vld_r,
  input wire [7:0] tx_byte_r,
  input wire wtx_ok_r,
  input wire mute_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // --------------------------------------------------------------------------
  // Outgoing block tracker
  // --------------------------------------------------------------------------
  reg [8:0] idx_r;
  reg [7:0] len_r;
  reg [7:0] pcb_r;
  reg [7:0] x_r;
  wire acc = tx_vld_r && tx_rdy;
  wire last = (idx_r > 9'h002) && (idx_r == {1'b0, len_r} + 9'h003);

  always @(posedge clk) begin
    if (!nrst) begin
      idx_r <= 9'h000;
      len_r <= 8'h00;
      pcb_r <= 8'h00;
      x_r <= 8'h00;
    end else if (acc) begin
      idx_r <= last ? 9'h000 : idx_r + 9'h001;
      x_r <= last ? 8'h00 : x_r ^ tx_byte_r;
      if (idx_r == 9'h001) begin
        pcb_r <= tx_byte_r;
      end
      if (idx_r == 9'h002) begin
        len_r <= tx_byte_r;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence s_stall;
    tx_vld_r && !tx_rdy;
  endsequence
  sequence s_held;
    tx_vld_r && $stable(tx_byte_r);
  endsequence

  a_nad_zero: assert property (acc && idx_r == 9'h000 |-> tx_byte_r == 8'h00)
    else $error("address byte not zero");
  a_i_reserved: assert property (acc && idx_r == 9'h001 && !tx_byte_r[7]
    |-> tx_byte_r[4:0] == 5'h00)
    else $error("I control byte reserved bits set");
  a_r_code: assert property (acc && idx_r == 9'h001 && tx_byte_r[7:6] == 2'b10
    |-> !tx_byte_r[5] && tx_byte_r[3:0] <= 4'h2)
    else $error("R control byte badly coded");
  a_s_type: assert property (acc && idx_r == 9'h001 && tx_byte_r[7:6] == 2'b11
    |-> tx_byte_r[4:0] <= 5'h03)
    else $error("S control byte type reserved");
  a_len_rfu: assert property (acc && idx_r == 9'h002 |-> tx_byte_r != 8'hFF)
    else $error("length byte reserved value");
  a_r_noinf: assert property (acc && idx_r == 9'h002 && pcb_r[7:6] == 2'b10
    |-> tx_byte_r == 8'h00)
    else $error("R block carries data");
  a_s_len: assert property (acc && idx_r == 9'h002 && pcb_r[7:6] == 2'b11
    |-> tx_byte_r == {7'h00, pcb_r[4:0] == 5'h01 || pcb_r[4:0] == 5'h03})
    else $error("S block length wrong");
  a_edc_xor: assert property (acc && last |-> tx_byte_r == x_r)
    else $error("check byte wrong");
  a_tx_hold: assert property (s_stall |=> s_held)
    else $error("outgoing byte dropped while stalled");
  a_mute_quiet: assert property (mute_r |-> !tx_vld_r)
    else $error("silent card transmits");
  a_wtx_pulse: assert property ($rose(wtx_ok_r) |=> !wtx_ok_r)
    else $error("extension flag longer than a cycle");
endmodule // tbl_link_asserts

bind tbl_link tbl_link_asserts u_chk (
  .clk(clk),
  .nrst(nrst),
  .tx_rdy(tx_rdy),
  .tx_vld_r(tx_vld_r),
  .tx_byte_r(tx_byte_r),
  .wtx_ok_r(wtx_ok_r),
  .mute_r(mute_r)
);

// ---- sim/tbl_term.sv ----
// Purpose: Terminal-side model that sends blocks and collects replies.
// Assumes: Bytes are strobed one per pulse with a gap cycle between them.
// Notes: Set slow to make the sink stall every other cycle.
`timescale 1ns/1ps
module tbl_term (
  input wire clk,
  output logic rx_vld,
  output logic [7:0] rx_byte,
  output logic rx_err,
  output logic tx_rdy,
  input wire tx_vld_r,
  input wire [7:0] tx_byte_r
);
  logic [7:0] got_q[$];
  logic slow;

  initial begin
    rx_vld = 1'b0;
    rx_byte = 8'hA5;
    rx_err = 1'b0;
    tx_rdy = 1'b1;
    slow = 1'b0;
  end

  always @(posedge clk) begin
    if (tx_vld_r && tx_rdy) begin
      got_q.push_back(tx_byte_r);
    end
    tx_rdy <= #1 slow ? ~tx_rdy : 1'b1;
  end

  // Between bytes the line shows the inverse so a stale value never passes.
  task automatic put(input logic [7:0] v);
    @(posedge clk);
    #1 rx_vld = 1'b1;
    rx_byte = v;
    @(posedge clk);
    #1 rx_vld = 1'b0;
    rx_byte = ~v;
  endtask

  task automatic send_blk(input logic [7:0] b[$], input logic [7:0] flip);
    logic [7:0] x;
    x = flip;
    repeat (4) @(posedge clk);
    foreach (b[i]) begin
      put(b[i]);
      x = x ^ b[i];
    end
    put(x);
  endtask
endmodule // tbl_term

// ---- sim/tbl_link_tb_top.sv ----
// Purpose: Self-checking bench for the card-side block link.
// Assumes: Card replies within a few hundred cycles of the check byte.
// Notes: Scenarios run in order; each depends on the sequence state left before.
`timescale 1ns/1ps
module tbl_link_tb_top;
  logic clk, nrst, bwt_timeout, app_tx_req, app_tx_more, wtx_req, ifs_req;
  logic [7:0] app_tx_len, app_tx_data, wtx_mult, ifs_val;
  wire rx_vld, rx_err, tx_rdy, tx_vld_r, app_rx_vld_r, app_rx_end_r, app_tx_take_r;
  wire wtx_ok_r, mute_r, link_idle_r;
  wire [7:0] rx_byte, tx_byte_r, app_rx_byte_r, ifsd_r;
  int fail_count, n_checks, end_cnt;
  logic [7:0] app_q[$];

  tbl_link dut (.clk(clk), .nrst(nrst), .rx_vld(rx_vld), .rx_byte(rx_byte),
    .rx_err(rx_err), .bwt_timeout(bwt_timeout), .tx_rdy(tx_rdy), .tx_vld_r(tx_vld_r),
    .tx_byte_r(tx_byte_r), .app_rx_vld_r(app_rx_vld_r), .app_rx_byte_r(app_rx_byte_r),
    .app_rx_end_r(app_rx_end_r), .app_tx_req(app_tx_req), .app_tx_len(app_tx_len),
    .app_tx_more(app_tx_more), .app_tx_data(app_tx_data), .app_tx_take_r(app_tx_take_r),
    .wtx_req(wtx_req), .wtx_mult(wtx_mult), .ifs_req(ifs_req), .ifs_val(ifs_val),
    .ifsd_r(ifsd_r), .wtx_ok_r(wtx_ok_r), .mute_r(mute_r), .link_idle_r(link_idle_r));
  tbl_term term (.clk(clk), .rx_vld(rx_vld), .rx_byte(rx_byte), .rx_err(rx_err),
    .tx_rdy(tx_rdy), .tx_vld_r(tx_vld_r), .tx_byte_r(tx_byte_r));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (app_rx_vld_r === 1'b1) app_q.push_back(app_rx_byte_r);
    if (app_rx_end_r === 1'b1) end_cnt++;
    if (app_tx_take_r === 1'b1) app_tx_data <= #1 app_tx_data + 8'h11;
  end

  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The expected check byte is appended here from the other bytes.
  task automatic chk_reply(input logic [7:0] e[$]);
    logic [7:0] x, g;
    int n;
    x = 8'h00;
    foreach (e[i]) x = x ^ e[i];
    e.push_back(x);
    for (n = 0; n < 3000 && term.got_q.size() < e.size(); n++) @(posedge clk);
    foreach (e[i]) begin
      g = (term.got_q.size() > 0) ? term.got_q.pop_front() : 8'hXX;
      cmp8(g, e[i]);
    end
  endtask

  task automatic close_out;
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_first_bad;
    term.send_blk('{8'h00, 8'h00, 8'h00}, 8'h01);
    chk_reply('{8'h00, 8'h81, 8'h00});
  endtask

  task automatic t_ifs;
    term.send_blk('{8'h00, 8'hC1, 8'h01, 8'hFE}, 8'h00);
    chk_reply('{8'h00, 8'hE1, 8'h01, 8'hFE});
    cmp8(ifsd_r, 8'hFE);
  endtask

  task automatic t_resynch;
    term.send_blk('{8'h00, 8'hC0, 8'h00}, 8'h00);
    chk_reply('{8'h00, 8'hE0, 8'h00});
  endtask

  task automatic t_chain;
    term.slow = 1'b1;
    term.send_blk('{8'h00, 8'h20, 8'h02, 8'h11, 8'h22}, 8'h00);
    chk_reply('{8'h00, 8'h90, 8'h00});
    term.slow = 1'b0;
  endtask

  task automatic t_unchained;
    @(posedge clk);
    #1 app_tx_req = 1'b1;
    app_tx_data = 8'h3C;
    term.send_blk('{8'h00, 8'h40, 8'h01, 8'h33}, 8'h00);
    chk_reply('{8'h00, 8'h00, 8'h02, 8'h3C, 8'h4D});
    #1 app_tx_req = 1'b0;
    cmp8(8'(app_q.size()), 8'h03);
    foreach (app_q[i]) cmp8(app_q[i], 8'h11 * (i + 1));
    cmp8(8'(end_cnt), 8'h01);
  endtask

  task automatic t_abort;
    term.send_blk('{8'h00, 8'hC2, 8'h00}, 8'h00);
    chk_reply('{8'h00, 8'hE2, 8'h00});
  endtask

  task automatic t_badlen;
    logic [7:0] b[$];
    b = '{8'h00, 8'h00, 8'h21};
    for (int i = 0; i < 33; i++) b.push_back(i[7:0]);
    term.send_blk(b, 8'h00);
    chk_reply('{8'h00, 8'h82, 8'h00});
  endtask

  task automatic t_wtx;
    logic ok;
    ok = 1'b0;
    @(posedge clk);
    #1 wtx_req = 1'b1;
    chk_reply('{8'h00, 8'hC3, 8'h01, 8'h05});
    #1 wtx_req = 1'b0;
    term.send_blk('{8'h00, 8'hE3, 8'h01, 8'h05}, 8'h00);
    for (int n = 0; n < 200 && !ok; n++) begin
      @(posedge clk);
      #2 ok = (wtx_ok_r === 1'b1);
    end
    cmp8({7'h00, ok}, 8'h01);
  endtask

  task automatic pulse_bwt;
    @(posedge clk);
    #1 bwt_timeout = 1'b1;
    @(posedge clk);
    #1 bwt_timeout = 1'b0;
  endtask

  // The card's size request goes unanswered twice; it resends once, then listens.
  task automatic t_ifs_retry;
    @(posedge clk);
    #1 ifs_req = 1'b1;
    ifs_val = 8'h40;
    chk_reply('{8'h00, 8'hC1, 8'h01, 8'h40});
    #1 ifs_req = 1'b0;
    pulse_bwt();
    chk_reply('{8'h00, 8'hC1, 8'h01, 8'h40});
    pulse_bwt();
    repeat (50) @(posedge clk);
    cmp8(8'(term.got_q.size()), 8'h00);
    cmp8({7'h00, link_idle_r}, 8'h01);
  endtask

  // Three bad blocks in a row silence the card until the next reset.
  task automatic t_mute;
    repeat (2) begin
      term.send_blk('{8'h00, 8'h00, 8'h00}, 8'h01);
      chk_reply('{8'h00, 8'h81, 8'h00});
    end
    term.send_blk('{8'h00, 8'h00, 8'h00}, 8'h01);
    repeat (50) @(posedge clk);
    cmp8({7'h00, mute_r}, 8'h01);
    cmp8(8'(term.got_q.size()), 8'h00);
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk);
    #1 cmp8({7'h00, mute_r}, 8'h00);
    cmp8({7'h00, link_idle_r}, 8'h01);
  endtask

  initial begin
    #400000;
    fail_count++;
    close_out();
  end

  initial begin
    fail_count = 0;
    n_checks = 0;
    end_cnt = 0;
    nrst = 1'b0;
    bwt_timeout = 1'b0;
    app_tx_req = 1'b0;
    app_tx_more = 1'b0;
    app_tx_len = 8'h02;
    app_tx_data = 8'h3C;
    wtx_req = 1'b0;
    wtx_mult = 8'h05;
    ifs_req = 1'b0;
    ifs_val = 8'h20;
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    @(posedge clk);
    #1 cmp8(ifsd_r, 8'h20);
    cmp8({7'h00, link_idle_r}, 8'h01);
    t_first_bad();
    t_ifs();
    t_resynch();
    t_chain();
    t_unchained();
    t_abort();
    t_badlen();
    t_wtx();
    t_ifs_retry();
    t_mute();
    close_out();
  end
endmodule // tbl_link_tb_top
